// ==== vfr_pkg.sv ====
/*
 * Constants and types of the vertex fetch stage: register map, fields and formats.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses on 8 bits.
 */
package vfr_pkg;
	localparam int NUM_ATTR_DEF = 2;
	localparam int NUM_SLOT_DEF = 2;

	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_RESTART   = 8'h04;
	localparam logic [7:0] REG_BIAS      = 8'h08;
	localparam logic [7:0] REG_ARRAY_BUF = 8'h0c;
	localparam logic [7:0] REG_INSTANCE  = 8'h10;
	localparam logic [7:0] REG_BASE_INST = 8'h14;
	localparam logic [7:0] REG_STATUS    = 8'h18;
	localparam logic [7:0] REG_VTX_CNT   = 8'h1c;
	localparam logic [7:0] REG_PRIM_CNT  = 8'h20;
	localparam logic [7:0] SLOT_BASE     = 8'h40;
	localparam logic [7:0] ATTR_BASE     = 8'h80;
	localparam int         SLOT_SHIFT    = 3;
	localparam int         ATTR_SHIFT    = 5;
	localparam logic [2:0] SF_OFFSET     = 3'h0;
	localparam logic [2:0] SF_SIZE       = 3'h4;
	localparam logic [4:0] AF_FORMAT     = 5'h00;
	localparam logic [4:0] AF_POINTER    = 5'h04;
	localparam logic [4:0] AF_STRIDE     = 5'h08;
	localparam logic [4:0] AF_DIVISOR    = 5'h0c;
	localparam logic [4:0] AF_SLOT       = 5'h10;
	localparam logic [4:0] AF_BINDING    = 5'h14;

	localparam int CTRL_RESTART_EN = 0;
	localparam int CTRL_FIXED_EN   = 1;
	localparam int CTRL_INDEXED    = 2;
	localparam int CTRL_PATCH      = 3;
	localparam int CTRL_ITYPE_LO   = 4;
	localparam int CTRL_ROBUST     = 6;
	localparam int CTRL_BITS       = 7;

	localparam int FMT_ENABLE  = 0;
	localparam int FMT_SIZE_LO = 1;
	localparam int FMT_TYPE_LO = 3;
	localparam int FMT_NORM    = 6;
	localparam int FMT_REV     = 7;
	localparam int FMT_BITS    = 8;

	localparam int ST_BUSY    = 0;
	localparam int ST_PATCH_OK = 1;

	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [31:0] ONE_INT    = 32'h0000_0001;
	localparam logic [31:0] ONE_FLOAT  = 32'h3f80_0000;
	localparam logic [31:0] ONE_FIX    = 32'h4000_0000;
	localparam logic [31:0] MASK_BYTE  = 32'h0000_00ff;
	localparam logic [31:0] MASK_HALF  = 32'h0000_ffff;
	localparam logic [31:0] MASK_WORD  = 32'hffff_ffff;

	typedef enum logic [1:0] {
		VFR_IDX_BYTE = 2'b00,
		VFR_IDX_HALF = 2'b01,
		VFR_IDX_WORD = 2'b10
	} vfr_itype_t;

	typedef enum logic [2:0] {
		VFR_INT32                    = 3'b000,
		VFR_FLOAT32                  = 3'b001,
		VFR_PACKED_UNSIGNED_WORD_FMT = 3'b010,
		VFR_PACKED_SIGNED_WORD_FMT   = 3'b011,
		VFR_PACKED_SMALL_FLOAT_FMT   = 3'b100
	} vfr_type_t;
endpackage

// ==== vfr_fetch_if.sv ====
/*
 * Address request carrier between the fetch sequencer and the address unit.
 * Assumes request fields hold while the answer is used.
 */
`timescale 1ns/100ps
interface vfr_fetch_if;
	logic [31:0] elem;
	logic [31:0] pointer;
	logic [31:0] stride;
	logic [31:0] binding;
	logic [31:0] slot_offset;
	logic [31:0] slot_size;
	logic [2:0]  nwords;
	logic        robust;
	logic [31:0] base_addr;
	logic        client;
	logic        zero;
	modport req  (output elem, pointer, stride, binding, slot_offset, slot_size, nwords,
		robust, input base_addr, client, zero);
	modport calc (input elem, pointer, stride, binding, slot_offset, slot_size, nwords,
		robust, output base_addr, client, zero);
endinterface

// ==== vfr_addr.sv ====
/*
 * Address unit: first byte of one attribute element and the out-of-range check.
 * Assumes a purely combinational use inside the sequencer's clock domain.
 */
`timescale 1ns/100ps
module vfr_addr (
	vfr_fetch_if.calc f
);
	import vfr_pkg::*;
	logic [63:0] span;
	logic [63:0] end_byte;

	assign span     = {32'h0000_0000, f.elem} * {32'h0000_0000, f.stride};
	assign f.client = (f.binding == RESET_WORD);    // [R19]
	// Buffer slot state only counts for buffer-sourced elements
	assign f.base_addr = f.client ? f.pointer + span[31:0] :                       // [R21]
		f.slot_offset + f.pointer + span[31:0];                                 // [R20]
	assign end_byte = {32'h0000_0000, f.pointer} + span + {59'h0, f.nwords, 2'b00};
	// Out-of-range element reads as zero and never reaches memory
	assign f.zero = f.robust && !f.client && (end_byte > {32'h0000_0000, f.slot_size}); // [R11]
endmodule

// ==== vfr_unpack.sv ====
/*
 * Element unpacker: turns fetched words into four 32-bit components.
 * Assumes words arrive low component first; output is integer, Q2.30 or float32.
 */
`timescale 1ns/100ps
module vfr_unpack (
	input  wire logic [2:0]   i_size,
	input  wire logic [2:0]   i_type,
	input  wire logic         i_norm,
	input  wire logic         i_rev,
	input  wire logic [127:0] i_words,
	output logic      [127:0] o_comp
);
	import vfr_pkg::*;

	function automatic logic [31:0] norm_u(input logic [9:0] c, input logic [41:0] maxv);
		logic [41:0] q;
		q = (({32'h0, c} << 30) + (maxv >> 1)) / maxv;
		return q[31:0];
	endfunction

	// Signed fields saturate at minus one
	function automatic logic [31:0] norm_s(input logic signed [31:0] c,
		input logic signed [31:0] maxv);
		logic signed [63:0] q;
		q = 64'(c);
		q = (q <<< 30) / 64'(maxv);
		if (q < -64'sd1073741824)
			q = -64'sd1073741824;
		return q[31:0];
	endfunction

	function automatic logic [31:0] ufloat(input logic [4:0] e, input logic [5:0] m,
		input int mb);
		logic [31:0] r;
		int          p;
		r = RESET_WORD;
		p = -1;
		if (e == 5'h1f) begin
			r = {1'b0, 8'hff, 23'(m) << (23 - mb)};
		end else if (e != 5'h00) begin
			r = {1'b0, 8'(e) + 8'd112, 23'(m) << (23 - mb)};
		end else if (m != 6'h00) begin
			for (int i = 0; i < 6; i++) begin
				if (m[i])
					p = i;
			end
			r = {1'b0, 8'(p + 113 - mb), 23'(m & ~(6'h01 << p)) << (23 - p)};
		end
		return r;
	endfunction

	logic [31:0] w0;
	logic [31:0] c [4];
	logic [9:0]  fx;
	logic [9:0]  fy;
	logic [9:0]  fz;
	logic [1:0]  fw;
	logic [31:0] one;

	assign w0 = i_words[31:0];

	always_comb begin
		fx  = i_rev ? w0[29:20] : w0[9:0];                   // [R15] [R16]
		fy  = w0[19:10];                                      // [R15] [R16]
		fz  = i_rev ? w0[9:0] : w0[29:20];                    // [R15] [R16]
		fw  = w0[31:30];                                      // [R15] [R16]
		one = ONE_INT;
		for (int i = 0; i < 4; i++)
			c[i] = i_words[32*i +: 32];
		case (i_type)
			VFR_INT32:   one = ONE_INT;
			VFR_FLOAT32: one = ONE_FLOAT;
			VFR_PACKED_UNSIGNED_WORD_FMT: begin
				if (i_norm) begin                                 // [R14]
					c[0] = norm_u(fx, 42'd1023);
					c[1] = norm_u(fy, 42'd1023);
					c[2] = norm_u(fz, 42'd1023);
					c[3] = norm_u({8'h00, fw}, 42'd3);
				end else begin                                    // [R12]
					c[0] = {22'h0, fx};
					c[1] = {22'h0, fy};
					c[2] = {22'h0, fz};
					c[3] = {30'h0, fw};
				end
			end
			VFR_PACKED_SIGNED_WORD_FMT: begin
				c[0] = {{22{fx[9]}}, fx};                          // [R13]
				c[1] = {{22{fy[9]}}, fy};
				c[2] = {{22{fz[9]}}, fz};
				c[3] = {{30{fw[1]}}, fw};
				if (i_norm) begin                                 // [R14]
					c[0] = norm_s(c[0], 32'sd511);
					c[1] = norm_s(c[1], 32'sd511);
					c[2] = norm_s(c[2], 32'sd511);
					c[3] = norm_s(c[3], 32'sd1);
				end
			end
			VFR_PACKED_SMALL_FLOAT_FMT: begin
				c[0] = ufloat(w0[10:6], w0[5:0], 6);               // [R17]
				c[1] = ufloat(w0[21:17], w0[16:11], 6);
				c[2] = ufloat(w0[31:27], {1'b0, w0[26:22]}, 5);
				c[3] = ONE_FLOAT;
			end
			default: one = ONE_INT;
		endcase
		if (i_type == VFR_INT32 || i_type == VFR_FLOAT32) begin
			if (i_size < 3'd2)
				c[1] = RESET_WORD;                                 // [R1]
			if (i_size < 3'd3)
				c[2] = RESET_WORD;                                 // [R1] [R2]
			if (i_size < 3'd4)
				c[3] = one;                                        // [R1] [R2] [R3] [R4]
		end
		o_comp = {c[3], c[2], c[1], c[0]};
	end
endmodule

// ==== vfr_top.sv ====
/*
 * Vertex fetch stage: register file, index intake with restart detection, per-attribute
 * fetch sequencer and four-component vertex output.
 * Assumes one 25 MHz clock, a memory acking each read word and a front end counting elements.
 */
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
//
// Summary of operation
// [R1] One stored component: x fetched, y z w become 0 0 1.
// [R2] Two stored components: x y fetched, z becomes 0, w becomes 1.
// [R3] Three stored components: x y z fetched, w becomes 1.
// [R4] Four stored components: all fetched, no defaults substituted.
// [R5] Restart index emits no vertex and starts a new primitive with the next index.
// [R6] Restart compare uses the raw index before the bias is added.
// [R7] Fixed restart uses all ones of the index width.
// [R8] With both restart enables on, the fixed all-ones value wins.
// [R9] Restart only in indexed draws; non-indexed streams are never split.
// [R10] Patch restart capability flag; false disables restart for patches.
// [R11] Robust access: out-of-range buffer fetch returns zero, no memory read.
// [R12] Packed unsigned word: x y z ten-bit, w two-bit unsigned.
// [R13] Packed signed word: fields are sign-extended two's complement.
// [R14] Normalized flag maps packed fields to zero..one or minus one..one.
// [R15] Normal order: x 9:0, y 19:10, z 29:20, w 31:30.
// [R16] Reversed order: w 31:30, x 29:20, y 19:10, z 9:0.
// [R17] Small float: x 10:0, y 21:11 eleven-bit, z 31:22 ten-bit.
// [R18] Specifying an array copies the current buffer binding into it.
// [R19] Non-zero binding fetches from a buffer, zero from client memory.
// [R20] Buffer address is relative offset plus slot offset plus element times stride.
// [R21] Client attributes ignore slot state, use own pointer and stride.
// [R22] Each attribute picks client memory or a buffer on its own.
// [R23] Zero divisor advances per vertex, otherwise once every divisor instances.
// [R24] Indices enter on valid and ready; vertices leave in the same order.
`timescale 1ns/100ps
module vfr_top #(
	parameter int          NUM_ATTR      = vfr_pkg::NUM_ATTR_DEF,
	parameter int          NUM_SLOT      = vfr_pkg::NUM_SLOT_DEF,
	parameter logic        PATCH_RESTART = 1'b1
) (
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_reset_n,
	input  wire logic [7:0]              i_avs_address,
	input  wire logic                    i_avs_read,
	input  wire logic                    i_avs_write,
	input  wire logic [31:0]             i_avs_writedata,
	input  wire logic [3:0]              i_avs_byteenable,
	output logic      [31:0]             o_avs_readdata,
	output logic                         o_avs_waitrequest,
	input  wire logic                    i_idx_valid,
	input  wire logic [31:0]             i_idx,
	input  wire logic                    i_idx_first,
	output logic                         o_idx_ready,
	output logic                         o_mem_req,
	output logic      [31:0]             o_mem_addr,
	output logic                         o_mem_client,
	output logic      [31:0]             o_mem_buffer,
	input  wire logic                    i_mem_ack,
	input  wire logic [31:0]             i_mem_rdata,
	output logic                         o_vtx_valid,
	input  wire logic                    i_vtx_ready,
	output logic                         o_vtx_first,
	output logic      [31:0]             o_vtx_id,
	output logic      [NUM_ATTR*128-1:0] o_vtx_data
);
	import vfr_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_SETUP = 3'b001,
		S_READ  = 3'b010,
		S_NEXT  = 3'b011,
		S_OUT   = 3'b100
	} vfr_state_t;

	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i])
				r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction

	function automatic logic [31:0] type_mask(input logic [1:0] t);
		logic [31:0] m;
		case (t)
			VFR_IDX_BYTE: m = MASK_BYTE;
			VFR_IDX_HALF: m = MASK_HALF;
			default:      m = MASK_WORD;
		endcase
		return m;
	endfunction

	logic [CTRL_BITS-1:0] ctrl_r;
	logic [31:0]          restart_r;
	logic [31:0]          bias_r;
	logic [31:0]          array_buf_r;
	logic [31:0]          instance_r;
	logic [31:0]          base_inst_r;
	logic [31:0]          vtx_cnt_r;
	logic [31:0]          prim_cnt_r;
	logic [31:0]          slot_off_r  [NUM_SLOT];
	logic [31:0]          slot_size_r [NUM_SLOT];
	logic [FMT_BITS-1:0]  fmt_r       [NUM_ATTR];
	logic [31:0]          ptr_r       [NUM_ATTR];
	logic [31:0]          stride_r    [NUM_ATTR];
	logic [31:0]          div_r       [NUM_ATTR];
	logic [31:0]          slot_sel_r  [NUM_ATTR];
	logic [31:0]          binding_r   [NUM_ATTR];

	logic        ack_r;
	logic        wr_go;
	logic [7:0]  ad;
	int          ai;
	int          si;
	logic        in_attr;
	logic        in_slot;
	logic [31:0] rd_nxt;

	vfr_state_t  state_r;
	int          attr_r;
	logic [2:0]  word_r;
	logic [127:0] words_r;
	logic        first_pend_r;
	logic [31:0] vidx_r;

	logic [31:0] raw_idx;
	logic [31:0] restart_val;
	logic        restart_ok;
	logic        restart_hit;
	logic [2:0]  nwords;
	logic [2:0]  cur_size;
	vfr_type_t   cur_type;
	logic [127:0] unpacked;

	vfr_fetch_if fif ();

	// Register bus: one wait state, then the access completes
	assign o_avs_waitrequest = !ack_r;
	assign wr_go   = i_avs_write && ack_r;
	assign ad      = i_avs_address;
	assign in_attr = (ad >= ATTR_BASE) && (int'((ad - ATTR_BASE) >> ATTR_SHIFT) < NUM_ATTR);
	assign in_slot = (ad >= SLOT_BASE) && (ad < ATTR_BASE) &&
		(int'((ad - SLOT_BASE) >> SLOT_SHIFT) < NUM_SLOT);
	assign ai      = int'((ad - ATTR_BASE) >> ATTR_SHIFT);
	assign si      = int'((ad - SLOT_BASE) >> SLOT_SHIFT);

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			ack_r <= 1'b0;
		else
			ack_r <= (i_avs_read || i_avs_write) && !ack_r;
	end

	always_comb begin
		rd_nxt = RESET_WORD;
		case (ad)
			REG_CTRL:      rd_nxt = {25'h0, ctrl_r};
			REG_RESTART:   rd_nxt = restart_r;
			REG_BIAS:      rd_nxt = bias_r;
			REG_ARRAY_BUF: rd_nxt = array_buf_r;
			REG_INSTANCE:  rd_nxt = instance_r;
			REG_BASE_INST: rd_nxt = base_inst_r;
			REG_STATUS:    rd_nxt = {30'h0, PATCH_RESTART, state_r != S_IDLE}; // [R10]
			REG_VTX_CNT:   rd_nxt = vtx_cnt_r;
			REG_PRIM_CNT:  rd_nxt = prim_cnt_r;
			default: begin
				if (in_slot && ad[2:0] == SF_OFFSET)
					rd_nxt = slot_off_r[si];
				else if (in_slot && ad[2:0] == SF_SIZE)
					rd_nxt = slot_size_r[si];
				else if (in_attr) begin
					case (ad[4:0])
						AF_FORMAT:  rd_nxt = {24'h0, fmt_r[ai]};
						AF_POINTER: rd_nxt = ptr_r[ai];
						AF_STRIDE:  rd_nxt = stride_r[ai];
						AF_DIVISOR: rd_nxt = div_r[ai];
						AF_SLOT:    rd_nxt = slot_sel_r[ai];
						AF_BINDING: rd_nxt = binding_r[ai];
						default:    rd_nxt = RESET_WORD;
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			o_avs_readdata <= RESET_WORD;
		else if (i_avs_read && !ack_r)
			o_avs_readdata <= rd_nxt;
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_r      <= '0;
			restart_r   <= RESET_WORD;
			bias_r      <= RESET_WORD;
			array_buf_r <= RESET_WORD;
			instance_r  <= RESET_WORD;
			base_inst_r <= RESET_WORD;
			for (int s = 0; s < NUM_SLOT; s++) begin
				slot_off_r[s]  <= RESET_WORD;
				slot_size_r[s] <= RESET_WORD;
			end
			for (int a = 0; a < NUM_ATTR; a++) begin
				fmt_r[a]      <= '0;
				ptr_r[a]      <= RESET_WORD;
				stride_r[a]   <= RESET_WORD;
				div_r[a]      <= RESET_WORD;
				slot_sel_r[a] <= RESET_WORD;
				binding_r[a]  <= RESET_WORD;
			end
		end else if (wr_go) begin
			case (ad)
				REG_CTRL:      ctrl_r <= CTRL_BITS'(merge_be({25'h0, ctrl_r},
					i_avs_writedata, i_avs_byteenable));
				REG_RESTART:   restart_r   <= merge_be(restart_r, i_avs_writedata,
					i_avs_byteenable);
				REG_BIAS:      bias_r      <= merge_be(bias_r, i_avs_writedata,
					i_avs_byteenable);
				REG_ARRAY_BUF: array_buf_r <= merge_be(array_buf_r, i_avs_writedata,
					i_avs_byteenable);
				REG_INSTANCE:  instance_r  <= merge_be(instance_r, i_avs_writedata,
					i_avs_byteenable);
				REG_BASE_INST: base_inst_r <= merge_be(base_inst_r, i_avs_writedata,
					i_avs_byteenable);
				default: begin
					if (in_slot && ad[2:0] == SF_OFFSET)
						slot_off_r[si] <= merge_be(slot_off_r[si], i_avs_writedata,
							i_avs_byteenable);
					else if (in_slot && ad[2:0] == SF_SIZE)
						slot_size_r[si] <= merge_be(slot_size_r[si], i_avs_writedata,
							i_avs_byteenable);
					else if (in_attr) begin
						case (ad[4:0])
							AF_FORMAT: begin
								fmt_r[ai]     <= FMT_BITS'(merge_be({24'h0, fmt_r[ai]},
									i_avs_writedata, i_avs_byteenable));
								binding_r[ai] <= array_buf_r;               // [R18]
							end
							AF_POINTER: begin
								ptr_r[ai]     <= merge_be(ptr_r[ai], i_avs_writedata,
									i_avs_byteenable);
								binding_r[ai] <= array_buf_r;               // [R18]
							end
							AF_STRIDE:  stride_r[ai] <= merge_be(stride_r[ai],
								i_avs_writedata, i_avs_byteenable);
							AF_DIVISOR: div_r[ai] <= merge_be(div_r[ai],
								i_avs_writedata, i_avs_byteenable);
							AF_SLOT:    slot_sel_r[ai] <= merge_be(slot_sel_r[ai],
								i_avs_writedata, i_avs_byteenable);
							default: ;
						endcase
					end
				end
			endcase
		end
	end

	// Restart detection on the raw, width-masked index
	assign raw_idx     = i_idx & type_mask(ctrl_r[CTRL_ITYPE_LO +: 2]);
	assign restart_val = ctrl_r[CTRL_FIXED_EN] ? type_mask(ctrl_r[CTRL_ITYPE_LO +: 2]) : // [R7] [R8]
		restart_r;
	assign restart_ok  = ctrl_r[CTRL_INDEXED] &&                                     // [R9]
		(ctrl_r[CTRL_RESTART_EN] || ctrl_r[CTRL_FIXED_EN]) &&
		!(ctrl_r[CTRL_PATCH] && !PATCH_RESTART);                                         // [R10]
	assign restart_hit = restart_ok && (raw_idx == restart_val);                     // [R6]

	assign o_idx_ready = (state_r == S_IDLE);                                      // [R24]
	assign o_vtx_valid = (state_r == S_OUT);                                       // [R24]
	assign o_mem_req   = (state_r == S_READ);

	assign cur_size = {1'b0, fmt_r[attr_r][FMT_SIZE_LO +: 2]} + 3'd1;
	assign cur_type = vfr_type_t'(fmt_r[attr_r][FMT_TYPE_LO +: 3]);
	assign nwords   = (cur_type == VFR_INT32 || cur_type == VFR_FLOAT32) ? cur_size : 3'd1;

	assign fif.elem        = (div_r[attr_r] == RESET_WORD) ? vidx_r :               // [R23]
		instance_r / div_r[attr_r] + base_inst_r;
	assign fif.pointer     = ptr_r[attr_r];
	assign fif.stride      = stride_r[attr_r];
	assign fif.binding     = binding_r[attr_r];
	assign fif.slot_offset = slot_off_r[int'(slot_sel_r[attr_r]) % NUM_SLOT];
	assign fif.slot_size   = slot_size_r[int'(slot_sel_r[attr_r]) % NUM_SLOT];
	assign fif.nwords      = nwords;
	assign fif.robust      = ctrl_r[CTRL_ROBUST];

	vfr_addr u_addr (
		.f (fif.calc)
	);

	vfr_unpack u_unpack (
		.i_size  (cur_size),
		.i_type  (cur_type),
		.i_norm  (fmt_r[attr_r][FMT_NORM]),
		.i_rev   (fmt_r[attr_r][FMT_REV]),
		.i_words (words_r),
		.o_comp  (unpacked)
	);

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_r      <= S_IDLE;
			attr_r       <= 0;
			word_r       <= 3'd0;
			words_r      <= '0;
			first_pend_r <= 1'b1;
			vidx_r       <= RESET_WORD;
			o_vtx_first  <= 1'b0;
			o_vtx_id     <= RESET_WORD;
			o_vtx_data   <= '0;
			o_mem_addr   <= RESET_WORD;
			o_mem_client <= 1'b0;
			o_mem_buffer <= RESET_WORD;
			vtx_cnt_r    <= RESET_WORD;
			prim_cnt_r   <= RESET_WORD;
		end else begin
			case (state_r)
				S_IDLE: begin
					if (i_idx_valid) begin
						if (restart_hit) begin                       // [R5]
							first_pend_r <= 1'b1;
							prim_cnt_r   <= prim_cnt_r + 32'd1;
						end else begin
							vidx_r       <= raw_idx + (ctrl_r[CTRL_INDEXED] ? bias_r : RESET_WORD); // [R6]
							o_vtx_first  <= first_pend_r || i_idx_first;
							first_pend_r <= 1'b0;
							attr_r       <= 0;
							state_r      <= S_SETUP;
						end
					end
				end
				S_SETUP: begin
					// Every attribute chooses its own source for this vertex
					o_mem_addr   <= fif.base_addr;                         // [R22]
					o_mem_client <= fif.client;                            // [R19] [R21]
					o_mem_buffer <= fif.binding;
					word_r       <= 3'd0;
					words_r      <= '0;
					if (fif.zero || !fmt_r[attr_r][FMT_ENABLE])            // [R11]
						state_r <= S_NEXT;
					else
						state_r <= S_READ;
				end
				S_READ: begin
					if (i_mem_ack) begin
						words_r[32*word_r +: 32] <= i_mem_rdata;
						word_r     <= word_r + 3'd1;
						o_mem_addr <= o_mem_addr + 32'd4;
						if (word_r == nwords - 3'd1)
							state_r <= S_NEXT;
					end
				end
				S_NEXT: begin
					o_vtx_data[128*attr_r +: 128] <= unpacked;
					if (attr_r == NUM_ATTR - 1)
						state_r <= S_OUT;
					else begin
						attr_r  <= attr_r + 1;
						state_r <= S_SETUP;
					end
				end
				S_OUT: begin
					o_vtx_id <= vidx_r;
					if (i_vtx_ready) begin                             // [R24]
						vtx_cnt_r <= vtx_cnt_r + 32'd1;
						state_r   <= S_IDLE;
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end
endmodule

// ==== vfr_top_asserts.sv ====
/* Port checker of the vertex fetch stage.
   Bound to vfr_top; sees only its ports. */
`timescale 1ns/100ps
module vfr_top_asserts #(
	parameter int NUM_ATTR = 2
) (
	input wire logic i_ref_clk, i_reset_n, i_avs_read, i_avs_write, o_avs_waitrequest,
	input wire logic i_idx_valid, o_idx_ready, o_mem_req, i_mem_ack, o_vtx_valid, i_vtx_ready,
	input wire logic [31:0]             o_mem_addr,
	input wire logic [NUM_ATTR*128-1:0] o_vtx_data
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	a_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=>
		!o_avs_waitrequest) else $error("bus answer late");
	a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("answer too long");
	a_out_excl: assert property (o_vtx_valid |-> !o_idx_ready && !o_mem_req)
		else $error("busy while vertex pending");
	a_vtx_hold: assert property (o_vtx_valid && !i_vtx_ready |=> o_vtx_valid && $stable(o_vtx_data))
		else $error("vertex changed before accept");
	a_req_hold: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
		else $error("fetch request dropped or moved");
	a_addr_step: assert property (o_mem_req && i_mem_ack |=> !o_mem_req || o_mem_addr == $past(o_mem_addr) + 32'h4)
		else $error("next word address wrong");
	a_back_idle: assert property (o_vtx_valid && i_vtx_ready |=> o_idx_ready && !o_vtx_valid)
		else $error("no return to idle after vertex");
	a_vtx_gap: assert property (i_idx_valid && o_idx_ready ##1 !o_idx_ready |-> !o_vtx_valid [*2])
		else $error("vertex too early after index");
	c_vertex: cover property (o_vtx_valid && i_vtx_ready);
	c_restart: cover property (i_idx_valid && o_idx_ready ##1 o_idx_ready);
	c_burst: cover property (o_mem_req && i_mem_ack ##1 o_mem_req);
endmodule
bind vfr_top vfr_top_asserts #(.NUM_ATTR(NUM_ATTR)) chk_u (.i_ref_clk(i_ref_clk),
	.i_reset_n(i_reset_n), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.o_avs_waitrequest(o_avs_waitrequest), .i_idx_valid(i_idx_valid), .o_idx_ready(o_idx_ready),
	.o_mem_req(o_mem_req), .i_mem_ack(i_mem_ack), .o_vtx_valid(o_vtx_valid),
	.i_vtx_ready(i_vtx_ready), .o_mem_addr(o_mem_addr), .o_vtx_data(o_vtx_data));

// ==== vfr_mem_model.sv ====
/* Vertex memory: one-cycle ack per read, optionally late: two cycles for the first word, one for the next.
   Word = address xor (buffer name << 16). */
`timescale 1ns/100ps
module vfr_mem_model (
	input  wire logic        i_clk, i_rst_n, i_req, i_slow,
	input  wire logic [31:0] i_addr, i_buffer,
	output logic             o_ack,
	output logic      [31:0] o_rdata
);
	logic [1:0] wait_r;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wait_r <= 2'h0;
			o_ack <= 1'b0;
			o_rdata <= 32'h0;
		end else if (i_req && !o_ack && wait_r >= {i_slow, 1'b0}) begin
			wait_r <= 2'h0;
			o_ack <= 1'b1;
			o_rdata <= i_addr ^ {i_buffer[15:0], 16'h0};
		end else begin
			// Data is not held after the ack
			wait_r <= i_req ? wait_r + 2'h1 : 2'h0;
			o_ack <= 1'b0;
			o_rdata <= ~o_rdata;
		end
	end
endmodule

// ==== tb.sv ====
/* Self-checking bench of the vertex fetch stage.
   Attribute 0 from client memory, attribute 1 packed from a buffer. */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
	$display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
	import vfr_pkg::*;
	logic i_ref_clk = 0, i_reset_n = 0, i_avs_read = 0, i_avs_write = 0, i_slow = 0;
	logic i_idx_valid = 0, i_idx_first = 1, i_vtx_ready = 0, sg = 0, rv = 0, oob = 0;
	logic o_avs_waitrequest, o_idx_ready, o_mem_req, o_mem_client, o_vtx_valid, o_vtx_first;
	logic i_mem_ack;
	logic [3:0]   i_avs_byteenable = 4'hf;
	logic [7:0]   i_avs_address = 8'h0;
	logic [31:0]  i_avs_writedata = 0, i_idx = 0, i_mem_rdata, o_avs_readdata, q;
	logic [31:0]  o_mem_addr, o_mem_buffer, o_vtx_id;
	logic [255:0] o_vtx_data;
	int           fail_count = 0, n_tests = 0, sz = 1;
	vfr_top dut_u (.*);
	vfr_mem_model mem_u (.i_clk(i_ref_clk), .i_rst_n(i_reset_n), .i_req(o_mem_req),
		.i_slow(i_slow), .i_addr(o_mem_addr), .i_buffer(o_mem_buffer), .o_ack(i_mem_ack),
		.o_rdata(i_mem_rdata));
	always #20 i_ref_clk = ~i_ref_clk;
	function automatic logic [31:0] ex(input logic [9:0] v, input logic s);
		return s ? {{22{v[9]}}, v} : {22'h0, v};
	endfunction
	function automatic logic [255:0] exp_vtx(input logic [31:0] e);
		logic [31:0] w;
		logic [255:0] r;
		w = (32'h48 + e * 4) ^ 32'hfe07_0000;
		for (int k = 0; k < 4; k++)
			r[32*k+:32] = k < sz ? 32'h100 + e * 16 + 4 * k : {31'h0, k == 3};
		r[255:128] = {ex({{8{sg & w[31]}}, w[31:30]}, sg), ex(rv ? w[9:0] : w[29:20], sg),
			ex(w[19:10], sg), ex(rv ? w[29:20] : w[9:0], sg)};
		if (oob)
			r[255:128] = 128'h0;
		return r;
	endfunction
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_write <= w;
		i_avs_read <= !w;
		do @(posedge i_ref_clk); while (o_avs_waitrequest !== 1'b0);
		q = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
		@(posedge i_ref_clk);
	endtask
	task automatic send(input logic [31:0] idx, input logic rs, input logic [31:0] e, input logic f);
		i_idx <= idx;
		i_idx_valid <= 1'b1;
		do @(posedge i_ref_clk); while (o_idx_ready !== 1'b1);
		i_idx_valid <= 1'b0;
		i_idx_first <= 1'b0;
		@(posedge i_ref_clk);
		`CHK("ready after take", rs, o_idx_ready)
		if (!rs) begin
			while (o_vtx_valid !== 1'b1) @(posedge i_ref_clk);
			i_vtx_ready <= 1'b1;
			@(posedge i_ref_clk);
			`CHK("data", exp_vtx(e), o_vtx_data)
			`CHK("id", e, o_vtx_id)
			`CHK("first", f, o_vtx_first)
			`CHK("source", 1'b0, o_mem_client)
			i_vtx_ready <= 1'b0;
		end
	endtask
	task end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		fail_count++;
		end_of_test();
	end
	initial begin
		repeat (16) @(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		@(posedge i_ref_clk);
		bus(1, ATTR_BASE + AF_STRIDE, 32'h10);
		bus(1, ATTR_BASE + AF_POINTER, 32'h100);
		bus(1, REG_ARRAY_BUF, 32'hfe07);
		bus(1, 8'ha4, 32'h8);
		bus(1, 8'ha8, 32'h4);
		bus(1, 8'hb0, 32'h1);
		bus(1, SLOT_BASE + 8'h8, 32'h40);
		bus(1, SLOT_BASE + 8'hc, 32'h1000);
		bus(0, 8'hb4, 0);
		`CHK("binding copy", 32'hfe07, q)
		bus(0, ATTR_BASE + AF_BINDING, 0);
		`CHK("client binding", 32'h0, q)
		bus(0, 8'h3c, 0);
		`CHK("unmapped", 32'h0, q)
		bus(0, REG_STATUS, 0);
		`CHK("patch flag", 1'b1, q[ST_PATCH_OK])
		bus(1, REG_BIAS, 32'h2);
		bus(1, REG_RESTART, 32'h5);
		bus(1, REG_CTRL, 32'h05);
		for (int i = 0; i < 4; i++) begin
			sz = i + 1;
			{rv, sg} = 2'(i);
			i_slow <= sg;
			bus(1, REG_ARRAY_BUF, 32'h0);
			bus(1, ATTR_BASE + AF_FORMAT, {29'h0, 2'(i), 1'b1});
			bus(1, REG_ARRAY_BUF, 32'hfe07);
			bus(1, 8'ha0, {24'h0, rv, 3'b001, sg, 3'b111});
			send(i, 0, i + 2, i == 0);
		end
		send(32'h5, 1, 0, 0);
		send(32'h3, 0, 32'h5, 1);
		bus(1, REG_CTRL, 32'h07);
		send(32'h5, 0, 32'h7, 0);
		send(32'hff, 1, 0, 0);
		bus(1, REG_CTRL, 32'h17);
		send(32'hffff, 1, 0, 0);
		bus(1, REG_CTRL, 32'h27);
		send(32'hffff_ffff, 1, 0, 0);
		bus(1, REG_CTRL, 32'h03);
		send(32'hff, 0, 32'hff, 1);
		bus(1, REG_CTRL, 32'h0f);
		send(32'hff, 1, 0, 0);
		bus(1, REG_CTRL, 32'h45);
		bus(1, SLOT_BASE + 8'hc, 32'h10);
		oob = 1'b1;
		send(32'h20, 0, 32'h22, 1);
		end_of_test();
	end
endmodule
